// *** ecdh_channel.sv ***
/*
 * one encoder / hall channel: decode, counter, phase and servo captures, hall status.
 * assumes pins and the phase / servo clocks arrive asynchronously to clk_sys.
 */
// Summary of operation
// - setting 3 or 7 counts four per cycle; the two differ in direction
// - phase clock falling edge copies counter into commutation latch
// - servo clock falling edge copies counter into loop latch
// - newer style loop latch holds 1/T extended count, 1/256 scale
// - older style offers edge interval timer beside loop latch, 1/512 scale
// - serial interface disabled makes the count readable in serial word A
// - 120 degree format flags all-high and all-low as invalid
// - 60 degree format accepts all-high and all-low as valid
// - demux select bit 1 clear shows U, V, W flags directly
// - demux select bit 1 set fills hall bits from C keyed by A, B
// - halls on A, B, C are counted edge by edge
// - setting 11 or 15 counts six per hall cycle; the two differ in direction
// - U, V, W states latched unprocessed into three hall status bits while demux select bit 1 is clear
`timescale 1ns/100ps
module ecdh_channel (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// sensor pins
	input wire logic encA,
	input wire logic encB,
	input wire logic encC,
	input wire logic hallU,
	input wire logic hallV,
	input wire logic hallW,
	// system clocks sampled as levels
	input wire logic phaseClk,
	input wire logic servoClk,
	// setup
	input wire logic [3:0] decodeControl,
	input wire logic [1:0] hallDemuxSelect,
	input wire logic newStyle,
	input wire logic hallFormat60,
	input wire logic serialIfDisable,
	// readable state
	output logic [31:0] commutationPositionLatch_q,
	output logic [31:0] loopPositionLatch_q,
	output logic [15:0] edgeIntervalTimer_q,
	output logic [31:0] serialWordA_q,
	output logic [2:0] hallStateBits_q,
	output logic hallInvalid_q,
	output logic countError_q
);
	wire logic [ecdh_pkg::IN_W-1:0] filt;
	logic [ecdh_pkg::CNT_W-1:0] count_q, count_d;
	logic [1:0] abPrev_q;
	logic [2:0] hallIdxPrev_q;
	logic phasePrev_q, servoPrev_q;
	logic [ecdh_pkg::TMR_W-1:0] sinceEdge_q, interval_q;
	logic [2:0] demux_q;

	ecdh_in_filter #(.W(ecdh_pkg::IN_W)) u_filt (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.pinIn({encA, encB, encC, hallU, hallV, hallW, phaseClk, servoClk}),
		.filtOut(filt)
	);

	wire logic fA = filt[7];
	wire logic fB = filt[6];
	wire logic fC = filt[5];
	wire logic [2:0] hallPins = filt[4:2];
	wire logic phaseNow = filt[1];
	wire logic servoNow = filt[0];

	////////////////////////////////////////////////////////////////////////////
	// decode

	// position of an A,B,C hall state in the 120 degree sequence
	function automatic logic [2:0] hallIdx(input logic [2:0] s);
		case (s)
			3'h4: hallIdx = 3'h0;
			3'h6: hallIdx = 3'h1;
			3'h2: hallIdx = 3'h2;
			3'h3: hallIdx = 3'h3;
			3'h1: hallIdx = 3'h4;
			3'h5: hallIdx = 3'h5;
			default: hallIdx = ecdh_pkg::HALL_BAD_IDX;
		endcase
	endfunction

	function automatic logic [2:0] wrapInc(input logic [2:0] i);
		wrapInc = (i == 3'h5) ? 3'h0 : i + 3'h1;
	endfunction

	wire logic modeX4 = (decodeControl == ecdh_pkg::DEC_X4_UP) ||
		(decodeControl == ecdh_pkg::DEC_X4_DN);
	wire logic modeX6 = (decodeControl == ecdh_pkg::DEC_X6_UP) ||
		(decodeControl == ecdh_pkg::DEC_X6_DN);
	// bit 2 of the setting flips which motion counts up
	wire logic invDir = decodeControl[2];

	wire logic [1:0] abNow = {fA, fB};
	wire logic aChg = abNow[1] ^ abPrev_q[1];
	wire logic bChg = abNow[0] ^ abPrev_q[0];
	wire logic qStep = aChg ^ bChg;
	// forward when the a line leads the b line
	wire logic qFwd = aChg ? (abNow[1] != abNow[0]) : (abNow[1] == abNow[0]);
	wire logic [2:0] hIdx = hallIdx({fA, fB, fC});
	wire logic hValid = (hIdx != ecdh_pkg::HALL_BAD_IDX) &&
		(hallIdxPrev_q != ecdh_pkg::HALL_BAD_IDX);
	wire logic hStep = hValid && (hIdx != hallIdxPrev_q);
	wire logic hFwd = (hIdx == wrapInc(hallIdxPrev_q));

	wire logic stepEv = (modeX4 && qStep) || (modeX6 && hStep);
	wire logic stepUp = (modeX4 ? qFwd : hFwd) ^ invDir;

	always_comb begin
		count_d = count_q;
		if (stepEv) begin
			count_d = stepUp ? count_q + 1'b1 : count_q - 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			count_q <= '0;
			abPrev_q <= '0;
			hallIdxPrev_q <= ecdh_pkg::HALL_BAD_IDX;
			countError_q <= 1'b0;
		end else begin
			count_q <= count_d;
			abPrev_q <= abNow;
			hallIdxPrev_q <= hIdx;
			// sticky: a double transition is lost for good
			if (modeX4 && aChg && bChg) begin
				countError_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// 1/T timing

	wire logic sinceSat = (sinceEdge_q == ecdh_pkg::TMR_MAX);
	wire logic [23:0] fracWide = (interval_q == '0) ? 24'h0 :
		({sinceEdge_q, 8'h00} / {8'h00, interval_q});
	// limited to just under one count so the extension never crosses the next edge
	wire logic [7:0] frac = (fracWide > {16'h0000, ecdh_pkg::FRAC_MAX}) ?
		ecdh_pkg::FRAC_MAX : fracWide[7:0];

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sinceEdge_q <= '0;
			interval_q <= '0;
		end else if (stepEv) begin
			sinceEdge_q <= '0;
			interval_q <= sinceSat ? sinceEdge_q : sinceEdge_q + 1'b1;
		end else if (!sinceSat) begin
			sinceEdge_q <= sinceEdge_q + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// captures

	wire logic phaseFall = phasePrev_q && !phaseNow;
	wire logic servoFall = servoPrev_q && !servoNow;
	wire logic [31:0] loopNew = {count_q, frac};
	wire logic [31:0] loopOld = {count_q[22:0], 9'h000};
	wire logic [31:0] loopVal = newStyle ? loopNew : loopOld;

	// latches only load on clock edges; no read path feeds back into them
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			phasePrev_q <= 1'b0;
			servoPrev_q <= 1'b0;
			commutationPositionLatch_q <= '0;
			loopPositionLatch_q <= '0;
			edgeIntervalTimer_q <= '0;
			serialWordA_q <= '0;
		end else begin
			phasePrev_q <= phaseNow;
			servoPrev_q <= servoNow;
			if (phaseFall) begin
				commutationPositionLatch_q <= {8'h00, count_q};
			end
			if (servoFall) begin
				loopPositionLatch_q <= loopVal;
				edgeIntervalTimer_q <= newStyle ? '0 : interval_q;
				serialWordA_q <= serialIfDisable ? loopVal : '0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// hall state

	wire logic demuxOn = hallDemuxSelect[ecdh_pkg::DEMUX_BIT];
	wire logic [2:0] hallSrc = demuxOn ? demux_q : hallPins;
	wire logic hallBad = !hallFormat60 && ((hallSrc == ecdh_pkg::HALL_ALL_LO) ||
		(hallSrc == ecdh_pkg::HALL_ALL_HI));

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			demux_q <= '0;
			hallStateBits_q <= '0;
			hallInvalid_q <= 1'b0;
		end else begin
			// the a,b pair picks the hall bit that c carries: 01 u, 10 v, 11 w
			case (abNow)
				2'h1: demux_q[2] <= fC;
				2'h2: demux_q[1] <= fC;
				2'h3: demux_q[0] <= fC;
				default: demux_q <= demux_q;
			endcase
			hallStateBits_q <= hallSrc;
			hallInvalid_q <= hallBad;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	a_phase_capture: assert property (phaseFall |=>
		commutationPositionLatch_q[23:0] == $past(count_q))
		else $error("commutation latch missed phase edge");
	a_servo_capture: assert property (servoFall && newStyle |=>
		loopPositionLatch_q[31:8] == $past(count_q))
		else $error("loop latch missed servo edge");
	a_new_frac: assert property (servoFall && newStyle |=>
		loopPositionLatch_q[7:0] == $past(frac))
		else $error("loop latch fraction wrong");
	a_old_scale: assert property (servoFall && !newStyle |=>
		loopPositionLatch_q[8:0] == 9'h000 && edgeIntervalTimer_q == $past(interval_q))
		else $error("old style scale or timer wrong");
	a_serial_word: assert property (servoFall && serialIfDisable |=>
		serialWordA_q == loopPositionLatch_q)
		else $error("serial word a differs from loop latch");
	a_x4_step: assert property (modeX4 && qStep && !(qFwd ^ invDir) |=>
		count_q == $past(count_q) - 1'b1)
		else $error("quadrature down count wrong");
	a_x6_step: assert property (modeX6 && hStep |=> count_q != $past(count_q))
		else $error("hall edge not counted");
	a_hall_invalid: assert property (!hallFormat60 &&
		hallSrc == ecdh_pkg::HALL_ALL_HI |=> hallInvalid_q)
		else $error("all-high hall state not flagged");
	a_hall_sixty: assert property (hallFormat60 |=> !hallInvalid_q)
		else $error("60 degree state flagged invalid");
	a_direct_hall: assert property (!demuxOn |=>
		hallStateBits_q == $past(hallPins))
		else $error("hall bits not direct");
	a_demux_u: assert property ((demuxOn && abNow == 2'h1) ##1 demuxOn |=>
		hallStateBits_q[2] == $past(fC, 2))
		else $error("demultiplexed u bit wrong");
	a_latch_hold: assert property (!phaseFall ##1 !phaseFall |->
		$stable(commutationPositionLatch_q))
		else $error("commutation latch changed without edge");
	a_idle_count: assert property (!modeX4 && !modeX6 |=> $stable(count_q))
		else $error("counter moved while decode off");

	c_x4_count: cover property (modeX4 && qStep ##1 servoFall);
	c_x6_count: cover property (modeX6 && hStep);
	c_demux: cover property (demuxOn && abNow == 2'h3);
	c_hall_bad: cover property (hallInvalid_q);
endmodule

// *** ecdh_pkg.sv ***
/*
 * constants shared by the encoder / hall front end.
 * assumes nothing beyond a systemverilog package scope.
 */
package ecdh_pkg;
	localparam int CNT_W = 24;
	localparam int LATCH_W = 32;
	localparam int TMR_W = 16;
	localparam int FRAC_NEW = 8;
	localparam int FRAC_OLD = 9;
	localparam logic [3:0] DEC_X4_UP = 4'h3;
	localparam logic [3:0] DEC_X4_DN = 4'h7;
	localparam logic [3:0] DEC_X6_UP = 4'hB;
	localparam logic [3:0] DEC_X6_DN = 4'hF;
	localparam int DEMUX_BIT = 1;
	localparam logic [1:0] DEMUX_DEFAULT = 2'h0;
	localparam logic [TMR_W-1:0] TMR_MAX = 16'hFFFF;
	localparam logic [7:0] FRAC_MAX = 8'hFF;
	localparam logic [2:0] HALL_ALL_LO = 3'h0;
	localparam logic [2:0] HALL_ALL_HI = 3'h7;
	localparam logic [2:0] HALL_BAD_IDX = 3'h7;
	localparam int IN_W = 8;
endpackage

// *** ecdh_in_filter.sv ***
/*
 * two-flop synchroniser followed by a three-sample two-of-three voter.
 * assumes asynchronous pin inputs; output is registered.
 */
`timescale 1ns/100ps
module ecdh_in_filter #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// pins in, filtered out
	input wire logic [W-1:0] pinIn,
	output logic [W-1:0] filtOut
);
	logic [W-1:0] meta_q, sync_q, dly1_q, dly2_q;
	wire logic [W-1:0] vote_d;

	// a level change lasting a single sample is rejected as a spike
	assign vote_d = (sync_q & dly1_q) | (sync_q & dly2_q) | (dly1_q & dly2_q);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			meta_q <= '0;
			sync_q <= '0;
			dly1_q <= '0;
			dly2_q <= '0;
			filtOut <= '0;
		end else begin
			meta_q <= pinIn;
			sync_q <= meta_q;
			dly1_q <= sync_q;
			dly2_q <= dly1_q;
			filtOut <= vote_d;
		end
	end
endmodule

// *** ecdh_sensor_model.sv ***
/*
 * sensor model: quadrature encoder or three hall sensors on A, B, C, stepped by the bench.
 * assumes one-cycle step requests at least 8 clk_sys cycles apart.
 */
`timescale 1ns/100ps
module ecdh_sensor_model (
	// clock
	input wire logic clk_sys,
	// step requests and format
	input wire logic stepFwd,
	input wire logic stepRev,
	input wire logic hallMode,
	// sensor lines
	output logic encA,
	output logic encB,
	output logic encC
);
	////////////////////////////////////////////////////////////////////////////////
	// forward: A leads B; the hall codes never reach all-low or all-high
	localparam logic [2:0] QUAD [4] = '{3'h0, 3'h4, 3'h6, 3'h2};
	localparam logic [2:0] HALL [6] = '{3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5};
	int pos = 0;
	int modN;
	assign modN = hallMode ? 6 : 4;
	assign {encA, encB, encC} = hallMode ? HALL[pos % 6] : QUAD[pos % 4];
	always @(posedge clk_sys) begin
		if (stepFwd)
			pos <= (pos + 1) % modN;
		else if (stepRev)
			pos <= (pos + modN - 1) % modN;
	end
endmodule

// *** testbench.sv ***
/*
 * self-checking bench for one encoder / hall channel.
 * assumes the sensor model on A, B, C and bench-driven hall flags and clocks.
 */
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin err_total++; \
	$display("BAD %s expected %0h seen %0h", nm, ex, gt); end end
module testbench;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic encA, encB, encC, stepFwd = 1'b0, stepRev = 1'b0, hallMode = 1'b0;
	logic hallU = 1'b0, hallV = 1'b0, hallW = 1'b0, phaseClk = 1'b0, servoClk = 1'b0;
	logic [3:0] decodeControl = ecdh_pkg::DEC_X4_UP;
	logic [1:0] hallDemuxSelect = ecdh_pkg::DEMUX_DEFAULT;
	logic newStyle = 1'b0, hallFormat60 = 1'b0, serialIfDisable = 1'b0;
	logic [31:0] comm, loopL, serA, base;
	logic [15:0] tmr;
	logic [2:0] hbits;
	logic hInv, cErr;
	int err_total = 0;
	int n_checks = 0;
	always #2.5 clk_sys = ~clk_sys;
	ecdh_sensor_model ecdh_sensor_model_inst (.clk_sys(clk_sys), .stepFwd(stepFwd),
		.stepRev(stepRev), .hallMode(hallMode), .encA(encA), .encB(encB), .encC(encC));
	ecdh_channel ecdh_channel_inst (.clk_sys(clk_sys), .resetn(resetn), .encA(encA),
		.encB(encB), .encC(encC), .hallU(hallU), .hallV(hallV), .hallW(hallW),
		.phaseClk(phaseClk), .servoClk(servoClk), .decodeControl(decodeControl),
		.hallDemuxSelect(hallDemuxSelect), .newStyle(newStyle), .hallFormat60(hallFormat60),
		.serialIfDisable(serialIfDisable), .commutationPositionLatch_q(comm),
		.loopPositionLatch_q(loopL), .edgeIntervalTimer_q(tmr), .serialWordA_q(serA),
		.hallStateBits_q(hbits), .hallInvalid_q(hInv), .countError_q(cErr));
	////////////////////////////////////////////////////////////////////////////////
	task automatic doReset();
		@(posedge clk_sys);
		resetn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		// let the input filter pipeline fill
		repeat (8) @(posedge clk_sys);
	endtask
	task automatic cap(input logic srv);
		@(posedge clk_sys);
		if (srv) servoClk <= 1'b1;
		else phaseClk <= 1'b1;
		repeat (4) @(posedge clk_sys);
		servoClk <= 1'b0;
		phaseClk <= 1'b0;
		repeat (10) @(posedge clk_sys);
	endtask
	task automatic step(input int n, input logic fwd);
		repeat (n) begin
			@(posedge clk_sys);
			stepFwd <= fwd;
			stepRev <= !fwd;
			@(posedge clk_sys);
			stepFwd <= 1'b0;
			stepRev <= 1'b0;
			repeat (6) @(posedge clk_sys);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_x4();
		cap(1'b0);
		base = comm;
		step(4, 1'b1);
		cap(1'b0);
		`CHK("x4 up count", base + 32'h0000_0004, comm)
		cap(1'b1);
		`CHK("old loop latch", {base[22:0] + 23'h4, 9'h000}, loopL)
		`CHK("edge interval", 16'h0008, tmr)
		decodeControl <= ecdh_pkg::DEC_X4_DN;
		step(4, 1'b1);
		cap(1'b0);
		`CHK("x4 down count", base, comm)
		`CHK("count error", 1'b0, cErr)
		$display("done x4 decode");
	endtask
	task automatic t_x6();
		hallMode <= 1'b1;
		newStyle <= 1'b1;
		serialIfDisable <= 1'b1;
		decodeControl <= ecdh_pkg::DEC_X6_UP;
		doReset();
		cap(1'b0);
		base = comm;
		step(6, 1'b1);
		cap(1'b0);
		`CHK("x6 up count", base + 32'h0000_0006, comm)
		decodeControl <= ecdh_pkg::DEC_X6_DN;
		step(6, 1'b1);
		cap(1'b0);
		`CHK("x6 down count", base, comm)
		cap(1'b1);
		`CHK("new loop latch", base[23:0], loopL[31:8])
		`CHK("serial word a", base[23:0], serA[31:8])
		$display("done x6 decode");
	endtask
	task automatic t_hall();
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_sys);
			{hallU, hallV, hallW} <= i[2:0];
			repeat (12) @(posedge clk_sys);
			`CHK("hall bits", i[2:0], hbits)
			`CHK("hall invalid", (i == 0 || i == 7) ? 1'b1 : 1'b0, hInv)
		end
		hallFormat60 <= 1'b1;
		repeat (12) @(posedge clk_sys);
		`CHK("60 format valid", 1'b0, hInv)
		$display("done hall flags");
	endtask
	task automatic t_demux();
		hallDemuxSelect <= 2'h2;
		decodeControl <= 4'h0;
		cap(1'b0);
		base = comm;
		step(2, 1'b1);
		repeat (2) @(posedge clk_sys);
		`CHK("demux at 010", 3'h0, hbits)
		step(1, 1'b1);
		repeat (2) @(posedge clk_sys);
		`CHK("demux at 011", 3'h4, hbits)
		step(2, 1'b1);
		repeat (2) @(posedge clk_sys);
		`CHK("demux at 101", 3'h6, hbits)
		cap(1'b0);
		`CHK("idle decode holds", base, comm)
		$display("done hall demux");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (8) @(posedge clk_sys);
		t_x4();
		t_hall();
		t_x6();
		t_demux();
		conclude();
	end
endmodule
